// *** logic/lsm_map.svh ***
// register offsets, field positions, reset values and fixed counts of the load/store multiple unit
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH
`define LSM_CTRL_OFF 8'h00
`define LSM_INSTR_OFF 8'h04
`define LSM_STATUS_OFF 8'h08
`define LSM_REGSEL_OFF 8'h0c
`define LSM_REGDATA_OFF 8'h10
`define LSM_CTRL_START 0
`define LSM_INSTR_RST 32'h0000_0000
`define LSM_REGSEL_RST 5'h00
`define LSM_PC_RST 32'h0c00_0003
`define LSM_SEL_USER 4
`define LSM_I_BLOCK 27
`define LSM_I_REGOFF 25
`define LSM_I_PRE 24
`define LSM_I_UP 23
`define LSM_I_SBIT 22
`define LSM_I_WB 21
`define LSM_I_LOAD 20
`define LSM_I_BASE 19:16
`define LSM_I_RD 15:12
`define LSM_I_LIST 15:0
`define LSM_I_IMM 11:0
`define LSM_I_SHAMT 11:7
`define LSM_I_SHKIND 6:5
`define LSM_I_RM 3:0
`define LSM_PSR_CARRY 29
`define LSM_PSR_INTS 27:26
`define LSM_MODE_FIELD 1:0
`define LSM_USER_MODE 2'h0
`define LSM_PC_MASK 32'h03ff_fffc
`define LSM_PROT_MASK 32'h0c00_0003
`define LSM_ADDR_HI 31:26
`define LSM_PREFETCH_BYTES 32'h0000_0008
`define LSM_STORE_PC_BYTES 32'h0000_000c
`define LSM_WORD_BYTES 32'h0000_0004
`endif

// *** logic/lsm_pkg.sv ***
// types shared by the load/store multiple unit
`default_nettype none
package lsm_pkg;
  typedef enum logic [1:0] {
    LSM_IDLE = 2'b00,
    LSM_CALC = 2'b01,
    LSM_XFER = 2'b10,
    LSM_DONE = 2'b11
  } lsm_state_e;
  typedef enum logic [1:0] {
    LSM_LOGICAL_LEFT_SHIFT = 2'b00,
    LSM_LOGICAL_RIGHT_SHIFT = 2'b01,
    LSM_ARITHMETIC_RIGHT_SHIFT = 2'b10,
    LSM_ROTATE_RIGHT = 2'b11
  } lsm_shift_e;
  typedef struct packed {
    logic req;
    logic write;
    logic [25:0] addr;
    logic [31:0] wdata;
  } lsm_mem_req_s;
  typedef struct packed {
    logic [31:0] rdata;
    logic memoryAbortInput;
  } lsm_mem_rsp_s;
endpackage
`default_nettype wire

// *** logic/lsm_offset_shifter.sv ***
// immediate-amount shifter for register offsets
`timescale 1ns/10ps
`default_nettype none
module lsm_offset_shifter (
  input wire logic [31:0] value,
  input wire logic [4:0] amount,
  input wire lsm_pkg::lsm_shift_e kind,
  input wire logic carryIn,
  output logic [31:0] result
);
  import lsm_pkg::*;
  always_comb begin
    case (kind)
      LSM_LOGICAL_LEFT_SHIFT: result = value << amount;
      // amount zero encodes a shift by 32
      LSM_LOGICAL_RIGHT_SHIFT: result = (amount == 5'h00) ? 32'h0000_0000 : value >> amount;
      LSM_ARITHMETIC_RIGHT_SHIFT: result = (amount == 5'h00) ? {32{value[31]}} : $signed(value) >>> amount;
      // rotate by zero is rotate-with-extend through carry
      LSM_ROTATE_RIGHT: result = (amount == 5'h00) ? {carryIn, value[31:1]} :
                                 (value >> amount) | (value << (6'h20 - {1'b0, amount}));
      default: result = value;
    endcase
  end
endmodule
`default_nettype wire

// *** logic/lsm_list_picker.sv ***
// lowest selected register and count of a register-selection mask
`timescale 1ns/10ps
`default_nettype none
module lsm_list_picker (
  input wire logic [15:0] mask,
  output logic [3:0] lowIdx,
  output logic [4:0] count,
  output logic anySet
);
  always_comb begin
    lowIdx = 4'h0;
    count = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i]) begin
        lowIdx = 4'(i);
        count = count + 5'h01;
      end
    end
  end
  assign anySet = |mask;
endmodule
`default_nettype wire

// *** logic/lsm_load_store_multiple_unit.sv ***
// load/store multiple unit: apb control, register banks, address generation and transfer sequencing
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lsm_map.svh"

// Summary of operation
// - mask bit n selects register n
// - transfer ascending, program counter last
// - lowest register gets lowest address
// - addresses from base, pre bit, up bit
// - stored program counter is plus twelve, with flags
// - loaded program counter; status bit picks status load
// - user mode protects interrupt and mode bits
// - user mode ignores status bit, mostly
// - privileged forced store reads user bank
// - privileged forced load writes user bank
// - block program counter base includes status bits
// - no write-back with program counter base
// - write-back ends second cycle, store starts it
// - base stored first is original, else updated
// - loaded base overrides written-back base
// - first address bits 31..26 trap
// - pre-index adds offset, write-back optional
// - post-index uses base, writes back unless aborted, trapped or program counter base
// - immediate offset is twelve-bit unsigned, up bit sets sign
// - register offset shifted by five-bit immediate
// - program counter base reads plus eight
// - trapped instruction runs on, transfers suppressed
// - only first address checked, others truncated
// - abort on any transfer, trap at end
module lsm_load_store_multiple_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output lsm_pkg::lsm_mem_req_s memRequest,
  input wire lsm_pkg::lsm_mem_rsp_s memResponse,
  output logic addrExceptionTrap,
  output logic dataAbortTrap
);
  import lsm_pkg::*;

  localparam logic [3:0] PcIdx = 4'hf;

  logic [31:0] userBank [0:14];
  logic [31:0] privBank [0:14];
  logic [31:0] pcReg_ff;
  lsm_state_e state_ff;
  logic [31:0] instr_ff;
  logic [4:0] regSel_ff;
  logic addrExc_ff, abortSeen_ff, done_ff;
  logic [15:0] remain_ff;
  logic [31:0] addr_ff, newBase_ff, pendData_ff;
  logic wbEff_ff, firstXfer_ff, pendValid_ff;
  logic [3:0] issueIdx_ff, pendIdx_ff;

  logic busy, apbWr, apbOk, startReq, abortNow, ldEn, excNow;
  logic isBlock, isLoad, isPre, isUp, sBit, wBit, userMode, forceUser, bankUser;
  logic [3:0] baseIdx, rdIdx, startLow, remainLow;
  logic [15:0] regList, startMask;
  logic [4:0] listCount;
  logic startAny, remainAny, wbEff;
  logic [31:0] shifted, offsetRaw, offsetAdj, pcFetch, pcStore, baseVal, span, firstAddr, newBase;
  logic [31:0] nextData, pcLoadVal, readData, rmVal;
  logic portEn, portUser;
  logic [3:0] portIdx;
  logic [31:0] portData;

  function automatic logic isMapped(input logic [7:0] addr);
    return addr == `LSM_CTRL_OFF || addr == `LSM_INSTR_OFF || addr == `LSM_STATUS_OFF ||
           addr == `LSM_REGSEL_OFF || addr == `LSM_REGDATA_OFF;
  endfunction

  function automatic logic [31:0] readReg(input logic [3:0] idx, input logic useUser);
    if (idx == PcIdx) return pcReg_ff;
    return useUser ? userBank[idx] : privBank[idx];
  endfunction

  // decode
  assign isBlock = instr_ff[`LSM_I_BLOCK];
  assign isLoad = instr_ff[`LSM_I_LOAD];
  assign isPre = instr_ff[`LSM_I_PRE];
  assign isUp = instr_ff[`LSM_I_UP];
  assign sBit = instr_ff[`LSM_I_SBIT];
  assign wBit = instr_ff[`LSM_I_WB];
  assign baseIdx = instr_ff[`LSM_I_BASE];
  assign rdIdx = instr_ff[`LSM_I_RD];
  assign regList = instr_ff[`LSM_I_LIST];
  assign userMode = pcReg_ff[`LSM_MODE_FIELD] == `LSM_USER_MODE;
  assign forceUser = isBlock && sBit && !userMode && (!isLoad || !regList[15]);
  assign bankUser = userMode || forceUser;
  assign startMask = isBlock ? regList : 16'h0001 << rdIdx;
  assign busy = state_ff != LSM_IDLE;

  lsm_list_picker u_pick_start (
    .mask(startMask),
    .lowIdx(startLow),
    .count(listCount),
    .anySet(startAny)
  );

  lsm_list_picker u_pick_remain (
    .mask(remain_ff),
    .lowIdx(remainLow),
    .count(),
    .anySet(remainAny)
  );

  // bank reads inside a process so register updates re-evaluate the offset
  always_comb rmVal = readReg(instr_ff[`LSM_I_RM], userMode);

  lsm_offset_shifter u_shifter (
    .value(rmVal),
    .amount(instr_ff[`LSM_I_SHAMT]),
    .kind(lsm_shift_e'(instr_ff[`LSM_I_SHKIND])),
    .carryIn(pcReg_ff[`LSM_PSR_CARRY]),
    .result(shifted)
  );

  // offset and base
  assign offsetRaw = instr_ff[`LSM_I_REGOFF] ? shifted : {20'h00000, instr_ff[`LSM_I_IMM]};
  assign offsetAdj = isUp ? offsetRaw : 32'h0000_0000 - offsetRaw;
  assign pcFetch = (pcReg_ff + `LSM_PREFETCH_BYTES) & `LSM_PC_MASK;
  assign pcStore = (pcReg_ff + `LSM_STORE_PC_BYTES) & `LSM_PC_MASK;
  assign span = {25'h0000000, listCount, 2'b00};

  always_comb begin
    baseVal = readReg(baseIdx, userMode);
    if (baseIdx == PcIdx) begin
      baseVal = isBlock ? ((pcReg_ff & ~`LSM_PC_MASK) | pcFetch) : pcFetch;
    end
  end

  always_comb begin
    if (!isBlock) begin
      firstAddr = isPre ? baseVal + offsetAdj : baseVal;
      newBase = baseVal + offsetAdj;
      wbEff = (!isPre || wBit) && baseIdx != PcIdx;
    end else begin
      if (isUp) begin
        firstAddr = isPre ? baseVal + `LSM_WORD_BYTES : baseVal;
        newBase = baseVal + span;
      end else begin
        firstAddr = isPre ? baseVal - span : baseVal - span + `LSM_WORD_BYTES;
        newBase = baseVal - span;
      end
      wbEff = wBit && baseIdx != PcIdx;
    end
  end

  assign excNow = |firstAddr[`LSM_ADDR_HI];

  // store data of the transfer issued next; base forwarded during the write-back cycle
  always_comb begin
    if (remainLow == PcIdx) begin
      nextData = (pcReg_ff & ~`LSM_PC_MASK) | pcStore;
    end else if (firstXfer_ff && isBlock && wbEff_ff && remainLow == baseIdx) begin
      nextData = newBase_ff;
    end else begin
      nextData = readReg(remainLow, bankUser);
    end
  end

  assign abortNow = state_ff == LSM_XFER && memRequest.req && memResponse.memoryAbortInput;

  // sequencer and memory request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= LSM_IDLE;
      remain_ff <= 16'h0000;
      addr_ff <= 32'h0000_0000;
      issueIdx_ff <= 4'h0;
      memRequest <= '0;
      firstXfer_ff <= 1'b0;
      newBase_ff <= 32'h0000_0000;
      wbEff_ff <= 1'b0;
    end else begin
      case (state_ff)
        LSM_IDLE: begin
          if (startReq) begin
            state_ff <= LSM_CALC;
          end
        end
        LSM_CALC: begin
          newBase_ff <= newBase;
          wbEff_ff <= wbEff;
          firstXfer_ff <= 1'b1;
          if (startAny) begin
            memRequest <= {!excNow, !isLoad, firstAddr[25:0],
                           startLow == PcIdx ? (pcReg_ff & ~`LSM_PC_MASK) | pcStore
                                             : readReg(startLow, bankUser)};
            issueIdx_ff <= startLow;
            remain_ff <= startMask & ~(16'h0001 << startLow);
            addr_ff <= firstAddr + `LSM_WORD_BYTES;
            state_ff <= LSM_XFER;
          end else begin
            state_ff <= LSM_DONE;
          end
        end
        LSM_XFER: begin
          firstXfer_ff <= 1'b0;
          if (remainAny) begin
            memRequest <= {!addrExc_ff, !isLoad, addr_ff[25:0], nextData};
            issueIdx_ff <= remainLow;
            remain_ff <= remain_ff & ~(16'h0001 << remainLow);
            addr_ff <= addr_ff + `LSM_WORD_BYTES;
          end else begin
            memRequest <= '0;
            state_ff <= LSM_DONE;
          end
        end
        LSM_DONE: state_ff <= LSM_IDLE;
        default: state_ff <= LSM_IDLE;
      endcase
    end
  end

  // status and traps
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addrExc_ff <= 1'b0;
      abortSeen_ff <= 1'b0;
      done_ff <= 1'b0;
      addrExceptionTrap <= 1'b0;
      dataAbortTrap <= 1'b0;
    end else begin
      addrExceptionTrap <= state_ff == LSM_DONE && addrExc_ff;
      dataAbortTrap <= state_ff == LSM_DONE && abortSeen_ff && !addrExc_ff;
      if (startReq) begin
        addrExc_ff <= 1'b0;
        abortSeen_ff <= 1'b0;
        done_ff <= 1'b0;
      end else begin
        if (state_ff == LSM_CALC) begin
          addrExc_ff <= excNow;
        end
        if (abortNow) begin
          abortSeen_ff <= 1'b1;
        end
        if (state_ff == LSM_DONE) begin
          done_ff <= 1'b1;
        end
      end
    end
  end

  // loaded word held one transfer so an abort can cancel it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pendValid_ff <= 1'b0;
      pendIdx_ff <= 4'h0;
      pendData_ff <= 32'h0000_0000;
    end else if (state_ff == LSM_XFER) begin
      pendValid_ff <= isLoad && memRequest.req && !abortNow;
      pendIdx_ff <= issueIdx_ff;
      pendData_ff <= memResponse.rdata;
    end else begin
      pendValid_ff <= 1'b0;
    end
  end

  assign ldEn = pendValid_ff && !abortSeen_ff && !abortNow;

  always_comb begin
    if (isBlock && sBit) begin
      pcLoadVal = userMode ? (pendData_ff & ~`LSM_PROT_MASK) | (pcReg_ff & `LSM_PROT_MASK)
                           : pendData_ff;
    end else begin
      pcLoadVal = (pendData_ff & `LSM_PC_MASK) | (pcReg_ff & ~`LSM_PC_MASK);
    end
  end

  // write port for software, base write-back and base restore
  always_comb begin
    portEn = 1'b0;
    portIdx = baseIdx;
    portUser = bankUser;
    portData = newBase_ff;
    if (apbOk && paddr == `LSM_REGDATA_OFF) begin
      portEn = 1'b1;
      portIdx = regSel_ff[3:0];
      portUser = regSel_ff[`LSM_SEL_USER];
      portData = pwdata;
    end else if (state_ff == LSM_XFER && firstXfer_ff && isBlock && wbEff_ff) begin
      portEn = 1'b1;
    end else if (state_ff == LSM_DONE && wbEff_ff) begin
      portEn = isBlock ? isLoad && (abortSeen_ff || addrExc_ff) : !(abortSeen_ff || addrExc_ff);
    end
  end

  // register banks; a load commit is written last so it wins over write-back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pcReg_ff <= `LSM_PC_RST;
    end else begin
      if (portEn) begin
        if (portIdx == PcIdx) begin
          pcReg_ff <= portData;
        end else if (portUser) begin
          userBank[portIdx] <= portData;
        end else begin
          privBank[portIdx] <= portData;
        end
      end
      if (ldEn) begin
        if (pendIdx_ff == PcIdx) begin
          pcReg_ff <= pcLoadVal;
        end else if (bankUser) begin
          userBank[pendIdx_ff] <= pendData_ff;
        end else begin
          privBank[pendIdx_ff] <= pendData_ff;
        end
      end
    end
  end

  // apb slave, zero wait states
  assign pready = 1'b1;
  assign apbWr = psel && penable && pwrite;
  assign pslverr = psel && penable && (!isMapped(paddr) || (pwrite && (busy || paddr == `LSM_STATUS_OFF)));
  assign apbOk = apbWr && !pslverr;
  assign startReq = apbOk && paddr == `LSM_CTRL_OFF && pwdata[`LSM_CTRL_START];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_ff <= `LSM_INSTR_RST;
      regSel_ff <= `LSM_REGSEL_RST;
    end else if (apbOk && paddr == `LSM_INSTR_OFF) begin
      instr_ff <= pwdata;
    end else if (apbOk && paddr == `LSM_REGSEL_OFF) begin
      regSel_ff <= pwdata[4:0];
    end
  end

  always_comb begin
    case (paddr)
      `LSM_CTRL_OFF: readData = {31'h0000_0000, busy};
      `LSM_INSTR_OFF: readData = instr_ff;
      `LSM_STATUS_OFF: readData = {28'h0000000, done_ff, abortSeen_ff, addrExc_ff, busy};
      `LSM_REGSEL_OFF: readData = {27'h0000000, regSel_ff};
      `LSM_REGDATA_OFF: readData = readReg(regSel_ff[3:0], regSel_ff[`LSM_SEL_USER]);
      default: readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readData;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  pc_last_a: assert property (memRequest.req && issueIdx_ff == PcIdx |-> remain_ff == 16'h0000)
    else $error("program counter transfer is not the last");
  ascend_order_a: assert property (state_ff == LSM_XFER && remainAny |=> issueIdx_ff > $past(issueIdx_ff))
    else $error("transfer order not ascending");
  addr_step_a: assert property (state_ff == LSM_XFER && remainAny && !addrExc_ff
                                |=> memRequest.addr == $past(memRequest.addr) + 26'h0000004)
    else $error("transfer address step is not four");
  desc_start_a: assert property (state_ff == LSM_CALC && isBlock && !isUp && isPre && startAny && !excNow
                                 |=> memRequest.addr == $past(baseVal[25:0]) - $past(span[25:0]))
    else $error("decrement start address wrong");
  addr_trap_a: assert property (state_ff == LSM_CALC && excNow |=> !memRequest.req ##1 !memRequest.req[*1])
    else $error("address exception did not suppress transfer");
  exc_no_write_a: assert property (addrExc_ff && state_ff == LSM_XFER |-> !memRequest.req)
    else $error("transfer issued after address exception");
  pc_base_wb_a: assert property (state_ff == LSM_CALC && baseIdx == PcIdx |=> !wbEff_ff)
    else $error("write-back with program counter base");
  post_wb_a: assert property (state_ff == LSM_CALC && !isBlock && !isPre && baseIdx != PcIdx |=> wbEff_ff)
    else $error("post-indexed transfer lost write-back");
  store_pc_a: assert property (memRequest.req && memRequest.write && issueIdx_ff == PcIdx
                               |-> memRequest.wdata[25:2] == pcReg_ff[25:2] + 24'h000003)
    else $error("stored program counter not plus twelve");
  wb_second_a: assert property (state_ff == LSM_XFER && firstXfer_ff && isBlock && wbEff_ff
                                |=> readReg(baseIdx, bankUser) == $past(newBase_ff))
    else $error("base not written back at end of second cycle");
  user_protect_a: assert property (state_ff == LSM_DONE && userMode && isBlock && isLoad
                                   |=> $stable(pcReg_ff[`LSM_PSR_INTS]) && $stable(pcReg_ff[1:0]))
    else $error("user load changed protected status bits");
  abort_trap_a: assert property (abortNow && !addrExc_ff |-> ##[1:17] dataAbortTrap)
    else $error("data abort trap not taken");

  block_load_c: cover property (state_ff == LSM_DONE && isBlock && isLoad && !abortSeen_ff);
  store_pc_c: cover property (memRequest.req && memRequest.write && issueIdx_ff == PcIdx);
  abort_mid_c: cover property (abortNow && !firstXfer_ff);
  addr_exc_c: cover property (addrExceptionTrap);
endmodule
`default_nettype wire

// *** test/lsm_memory_model.sv ***
// memory system and memory manager model facing the transfer port
`timescale 1ns/10ps
`default_nettype none
module lsm_memory_model (
  input wire logic ref_clk,
  input wire lsm_pkg::lsm_mem_req_s memRequest,
  output var lsm_pkg::lsm_mem_rsp_s memResponse,
  input wire logic abortOn,
  input wire logic [25:0] abortAddr
);
  import lsm_pkg::*;
  logic [31:0] words [0:255];
  logic [31:0] lastData = 32'h0000_0000;
  // same-cycle answer; an idle bus shows the inverse of the last word
  always_comb begin
    memResponse.rdata = memRequest.req ? words[memRequest.addr[9:2]] : ~lastData;
    memResponse.memoryAbortInput = memRequest.req && abortOn && (memRequest.addr == abortAddr);
  end
  always @(posedge ref_clk) begin
    if (memRequest.req) begin
      lastData <= memResponse.rdata;
      // the manager blocks an aborted store itself
      if (memRequest.write && !memResponse.memoryAbortInput) words[memRequest.addr[9:2]] <= memRequest.wdata;
    end
  end
endmodule
`default_nettype wire

// *** test/lsm_load_store_multiple_unit_bench.sv ***
// self-checking bench for the load/store multiple unit
`timescale 1ns/10ps
`default_nettype none
`include "lsm_map.svh"
module lsm_load_store_multiple_unit_bench;
  import lsm_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, addrExceptionTrap, dataAbortTrap, abortOn, err;
  logic [7:0] paddr;
  logic [25:0] abortAddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] adrQ[$];
  logic [31:0] datQ[$];
  lsm_mem_req_s memRequest;
  lsm_mem_rsp_s memResponse;
  int n_errors = 0;
  int compares = 0;
  int nA = 0;
  int nD = 0;
  lsm_load_store_multiple_unit dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .memRequest, .memResponse, .addrExceptionTrap, .dataAbortTrap);
  lsm_memory_model mem (.ref_clk, .memRequest, .memResponse, .abortOn, .abortAddr);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (memRequest.req === 1'b1) begin
      adrQ.push_back({6'h00, memRequest.addr});
      datQ.push_back(memRequest.wdata);
    end
    if (addrExceptionTrap === 1'b1) nA++;
    if (dataAbortTrap === 1'b1) nD++;
  end
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic setR(input logic b, input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, `LSM_REGSEL_OFF, {27'h0, b, i});
    apb(1'b1, `LSM_REGDATA_OFF, v);
  endtask
  task automatic getR(input logic b, input logic [3:0] i);
    apb(1'b1, `LSM_REGSEL_OFF, {27'h0, b, i});
    apb(1'b0, `LSM_REGDATA_OFF, 32'h0);
  endtask
  task automatic run(input logic [31:0] ins);
    int n;
    adrQ.delete();
    datQ.delete();
    nA = 0;
    nD = 0;
    apb(1'b1, `LSM_INSTR_OFF, ins);
    apb(1'b1, `LSM_CTRL_OFF, 32'h1);
    n = 0;
    do begin
      apb(1'b0, `LSM_STATUS_OFF, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 30);
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask
  function automatic logic [31:0] mi(input logic p, u, s, w, l, input logic [3:0] b, input logic [15:0] lst);
    return {4'h0, 3'b100, p, u, s, w, l, b, lst};
  endfunction
  function automatic logic [31:0] si(input logic r, p, u, w, l, input logic [3:0] b, d, input logic [11:0] o);
    return {4'h0, 2'b01, r, p, u, 1'b0, w, l, b, d, o};
  endfunction
  task automatic seq(input int n, input logic [31:0] a0);
    chk("transfer count", 32'(n), 32'(adrQ.size()));
    for (int i = 0; i < n; i++) chk("address", a0 + 32'(4 * i), adrQ[i]);
  endtask
  task automatic t_reset;
    getR(1'b0, 4'hf);
    chk("pc reset", `LSM_PC_RST, q);
    chk("ready", 32'h1, {31'h0, pready});
    apb(1'b1, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_store;
    setR(1'b0, 4'h1, 32'h11);
    setR(1'b0, 4'h2, 32'h100);
    setR(1'b0, 4'h5, 32'h55);
    run(mi(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 16'h0026));
    seq(3, 32'h100);
    chk("stored r1", 32'h11, datQ[0]);
    chk("stored base second", 32'h10c, datQ[1]);
    chk("stored r5", 32'h55, datQ[2]);
    setR(1'b0, 4'h3, 32'h33);
    run(mi(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h2, 16'h000c));
    seq(2, 32'h104);
    chk("stored base first", 32'h10c, datQ[0]);
    getR(1'b0, 4'h2);
    chk("written-back base", 32'h104, q);
    setR(1'b0, 4'hf, 32'h2000_1003);
    run(mi(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 16'h8000));
    chk("stored pc", 32'h2000_100f, datQ[0]);
  endtask
  task automatic t_forced;
    setR(1'b1, 4'h6, 32'haaaa);
    setR(1'b0, 4'h6, 32'h5555);
    setR(1'b0, 4'h7, 32'h40);
    // forced user bank without write-back, registers read many cycles later
    run(mi(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h7, 16'h0040));
    chk("forced store", 32'haaaa, datQ[0]);
    mem.words[16] = 32'h1234;
    run(mi(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h7, 16'h0040));
    getR(1'b1, 4'h6);
    chk("user r6", 32'h1234, q);
    getR(1'b0, 4'h6);
    chk("privileged r6", 32'h5555, q);
  endtask
  task automatic t_pcload;
    setR(1'b0, 4'h4, 32'h80);
    mem.words[32] = 32'h5000_4001;
    run(mi(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h4, 16'h8000));
    getR(1'b0, 4'hf);
    chk("pc load status kept", 32'h2000_4003, q);
    run(mi(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h4, 16'h8000));
    getR(1'b0, 4'hf);
    chk("pc load status taken", 32'h5000_4001, q);
    setR(1'b0, 4'hf, 32'h0000_2000);
    setR(1'b1, 4'h4, 32'h80);
    mem.words[32] = 32'hfc00_3003;
    run(mi(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h4, 16'h8000));
    getR(1'b1, 4'hf);
    chk("user pc load", 32'hf000_3000, q);
    setR(1'b1, 4'h6, 32'h66);
    run(mi(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h4, 16'h0040));
    chk("user store s ignored", 32'h66, datQ[0]);
    setR(1'b0, 4'hf, 32'h0000_0003);
  endtask
  task automatic t_trap;
    setR(1'b0, 4'h8, 32'h0400_0000);
    run(mi(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 16'h0003));
    chk("trapped transfers", 32'h0, 32'(adrQ.size()));
    chk("address trap", 32'h1, 32'(nA));
    setR(1'b0, 4'h8, 32'h03ff_fffc);
    run(mi(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 16'h0003));
    chk("wrap address", 32'h0, adrQ[1]);
    chk("no wrap trap", 32'h0, 32'(nA));
    setR(1'b0, 4'hf, 32'h0c00_1003);
    run(mi(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, 16'h0001));
    chk("pc base trap", 32'h1, 32'(nA));
    getR(1'b0, 4'hf);
    chk("pc base no write-back", 32'h0c00_1003, q);
    setR(1'b0, 4'hf, 32'h0000_0003);
  endtask
  task automatic t_loads;
    setR(1'b0, 4'h9, 32'h100);
    mem.words[64] = 32'h77;
    mem.words[65] = 32'h88;
    run(mi(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'h9, 16'h0600));
    getR(1'b0, 4'h9);
    chk("loaded base", 32'h77, q);
    setR(1'b0, 4'h9, 32'h100);
    setR(1'b0, 4'h2, 32'hdead);
    abortOn <= 1'b1;
    abortAddr <= 26'h104;
    run(mi(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h9, 16'h0007));
    abortOn <= 1'b0;
    chk("abort trap", 32'h1, 32'(nD));
    getR(1'b0, 4'h2);
    chk("r2 after abort", 32'hdead, q);
  endtask
  task automatic t_single;
    setR(1'b0, 4'h2, 32'h108);
    run(si(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h2, 4'h1, 12'h004));
    chk("pre address", 32'h104, adrQ[0]);
    getR(1'b0, 4'h1);
    chk("single load", 32'h88, q);
    run(si(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2, 4'h1, 12'h008));
    chk("post address", 32'h108, adrQ[0]);
    setR(1'b0, 4'h3, 32'h5);
    run(si(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h2, 4'h1, 12'h103));
    chk("shifted offset", 32'h124, adrQ[0]);
    getR(1'b0, 4'h2);
    chk("base updates", 32'h124, q);
    setR(1'b0, 4'hf, 32'h0000_0103);
    run(si(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'hf, 4'h1, 12'h000));
    chk("pc base address", 32'h108, adrQ[0]);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    abortOn = 1'b0;
    abortAddr = 26'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_store();
    t_forced();
    t_pcload();
    t_trap();
    t_loads();
    t_single();
    give_verdict();
  end
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
